// ===== verilog/ddrio_gearbox.sv
// file: top of the per-pin output, tristate, memory input and gearbox logic
`timescale 1ns/10ps

// ------------------------------------------------------------
// pin register block
// ------------------------------------------------------------
module ddrio_gearbox
    import ddrio_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] out_mode_in,
    input wire logic latch_mode_in,
    input wire logic out_data_rise_in,
    input wire logic out_data_fall_in,
    input wire logic tristate_ctrl_in,
    input wire logic write_strobe_shifted_in,
    input wire logic read_strobe_shifted_in,
    input wire logic sync_clock_polarity_in,
    input wire logic pin_data_in,
    output logic pin_data_out,
    output logic pin_oe_out,
    output logic [1:0] mem_rd_data_out,
    input wire logic fast_edge_clock_in,
    input wire logic ser_data_a_in,
    input wire logic ser_data_b_in,
    input wire logic [1:0] gb_mode_in,
    input wire logic word_align_req_in,
    output logic [7:0] gb_word_out,
    output logic gb_word_valid_out
);

    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_r <= DDRIO_SYNC_RST;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // pins and strobes are foreign to clk_in: two flops each
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    assign async_in = {write_strobe_shifted_in, read_strobe_shifted_in,
                       sync_clock_polarity_in, pin_data_in,
                       fast_edge_clock_in, ser_data_a_in, ser_data_b_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    logic wstb_s;
    logic rstb_s;
    logic pol_s;
    logic pin_s;
    logic eclk_s;
    logic ser_a_s;
    logic ser_b_s;
    assign {wstb_s, rstb_s, pol_s, pin_s, eclk_s, ser_a_s, ser_b_s} = sync2_r;

    // previous samples for edge detection
    logic wstb_d_r;
    logic rstb_d_r;
    logic eclk_d_r;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wstb_d_r <= 1'b0;
            rstb_d_r <= 1'b0;
            eclk_d_r <= 1'b0;
        end else begin
            wstb_d_r <= wstb_s;
            rstb_d_r <= rstb_s;
            eclk_d_r <= eclk_s;
        end
    end

    logic wstb_rise;
    logic rstb_rise;
    logic rstb_fall;
    logic eclk_rise;
    logic eclk_fall;
    assign wstb_rise = wstb_s && !wstb_d_r;
    assign rstb_rise = rstb_s && !rstb_d_r;
    assign rstb_fall = !rstb_s && rstb_d_r;
    assign eclk_rise = eclk_s && !eclk_d_r;
    assign eclk_fall = !eclk_s && eclk_d_r;

    // ------------------------------------------------------------
    // output register stages
    // ------------------------------------------------------------
    logic rise_stage_reg_r;
    logic fall_hold_r;
    logic fall_stage_reg_r;
    logic sdr_latch;
    logic mem_mode;
    assign mem_mode = (out_mode_in == DDRIO_OUT_MEMORY);

    // rising edge stage: both data inputs taken together
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rise_stage_reg_r <= 1'b0;
            fall_hold_r <= 1'b0;
        end else begin
            rise_stage_reg_r <= out_data_rise_in;
            fall_hold_r <= out_data_fall_in;
        end
    end

    // falling edge moves held fall data into the fall stage
    always_ff @(negedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fall_stage_reg_r <= 1'b0;
        end else begin
            fall_stage_reg_r <= fall_hold_r;
        end
    end

    // latch variant is transparent while clk is high; timing is on the user
    always_latch begin
        if (!rst_n) begin
            sdr_latch = 1'b0;
        end else if (clk_in) begin
            sdr_latch = out_data_rise_in;
        end
    end

    // pin mux: clock in generic mode, write strobe in memory mode
    always_comb begin
        case (out_mode_in)
            DDRIO_OUT_SINGLE:
                pin_data_out = latch_mode_in ? sdr_latch : rise_stage_reg_r;
            DDRIO_OUT_GENERIC:
                pin_data_out = clk_in ? rise_stage_reg_r
                                      : fall_stage_reg_r;
            DDRIO_OUT_MEMORY:
                pin_data_out = wstb_s ? rise_stage_reg_r
                                      : fall_stage_reg_r;
            default: pin_data_out = rise_stage_reg_r;
        endcase
    end

    // ------------------------------------------------------------
    // tristate registers
    // ------------------------------------------------------------
    logic tristate_reg_r;
    logic tristate_mem_r;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tristate_reg_r <= 1'b0;
            tristate_mem_r <= 1'b0;
        end else begin
            tristate_reg_r <= tristate_ctrl_in;
            if (wstb_rise) begin
                tristate_mem_r <= tristate_reg_r;
            end
        end
    end
    assign pin_oe_out = mem_mode ? tristate_mem_r : tristate_reg_r;

    // ------------------------------------------------------------
    // memory mode read capture and resync
    // ------------------------------------------------------------
    logic cap_rise_r;
    logic cap_fall_r;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cap_rise_r <= 1'b0;
            cap_fall_r <= 1'b0;
        end else begin
            if (rstb_rise) begin
                cap_rise_r <= pin_s;
            end
            if (rstb_fall) begin
                cap_fall_r <= pin_s;
            end
        end
    end

    // resync point chosen by polarity: rising or falling strobe edge
    logic resync_take;
    assign resync_take = pol_s ? rstb_rise : rstb_fall;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_data_out <= 2'b00;
        end else if (resync_take) begin
            mem_rd_data_out <= {cap_fall_r, cap_rise_r};
        end
    end

    // ------------------------------------------------------------
    // input gearbox
    // ------------------------------------------------------------
    logic eclk_edge;
    assign eclk_edge = eclk_rise || eclk_fall; // double-rate sampling

    ddrio_deser u_deser (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .gb_mode_in(gb_mode_in),
        .bit_a_valid_in(eclk_edge),
        .bit_a_in(ser_a_s),
        .bit_b_valid_in(eclk_edge),
        .bit_b_in(ser_b_s),
        .word_align_req_in(word_align_req_in),
        .word_out(gb_word_out),
        .word_valid_out(gb_word_valid_out)
    );

endmodule // ddrio_gearbox

// ===== include/ddrio_pkg.sv
// package: mode encodings, gearbox widths and lane positions for the pin register block
package ddrio_pkg;

    // output path modes
    typedef enum logic [1:0] {
        DDRIO_OUT_SINGLE  = 2'b00,
        DDRIO_OUT_GENERIC = 2'b01,
        DDRIO_OUT_MEMORY  = 2'b10
    } ddrio_out_mode_e;

    // gearbox modes
    typedef enum logic [1:0] {
        DDRIO_GB_BY7     = 2'b00,
        DDRIO_GB_BY8     = 2'b01,
        DDRIO_GB_DUAL_BY4 = 2'b10
    } ddrio_gb_mode_e;

    localparam int DDRIO_WORD_W = 8;
    localparam int DDRIO_BY7_LEN = 7;
    localparam int DDRIO_BY8_LEN = 8;
    localparam int DDRIO_BY4_LEN = 4;
    localparam logic [3:0] DDRIO_CNT_ZERO = 4'h0;
    localparam logic [3:0] DDRIO_CNT_ONE = 4'h1;
    localparam logic [2:0] DDRIO_LANE_HI = 3'h4; // first 1:4 gearbox lanes 7..4
    localparam logic [7:0] DDRIO_WORD_RST = 8'h00;
    localparam logic [1:0] DDRIO_SYNC_RST = 2'h0;

endpackage

// ===== verilog/ddrio_deser.sv
// file: bottom-edge input gearbox, serial on sampled edge clock to parallel word
`timescale 1ns/10ps

module ddrio_deser
    import ddrio_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] gb_mode_in,
    input wire logic bit_a_valid_in,
    input wire logic bit_a_in,
    input wire logic bit_b_valid_in,
    input wire logic bit_b_in,
    input wire logic word_align_req_in,
    output logic [7:0] word_out,
    output logic word_valid_out
);

    // ------------------------------------------------------------
    // word length per mode
    // ------------------------------------------------------------
    function automatic logic [3:0] ddrio_len(input logic [1:0] m);
        case (m)
            DDRIO_GB_BY7: ddrio_len = 4'(DDRIO_BY7_LEN);
            DDRIO_GB_BY8: ddrio_len = 4'(DDRIO_BY8_LEN);
            default: ddrio_len = 4'(DDRIO_BY4_LEN);
        endcase
    endfunction

    logic [7:0] shift_a_r;
    logic [3:0] shift_b_r;
    logic [3:0] count_r;
    logic [3:0] len;
    logic [7:0] word_nxt;

    assign len = ddrio_len(gb_mode_in);

    // shift registers; lane b only used by the second 1:4 gearbox
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_a_r <= DDRIO_WORD_RST;
            shift_b_r <= 4'h0;
        end else begin
            if (bit_a_valid_in) begin
                shift_a_r <= {shift_a_r[6:0], bit_a_in};
            end
            if (bit_b_valid_in) begin
                shift_b_r <= {shift_b_r[2:0], bit_b_in};
            end
        end
    end

    // bit counter; each bit that arrives while the align request is high slips the boundary by one bit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= DDRIO_CNT_ZERO;
        end else if (bit_a_valid_in) begin
            if (word_align_req_in) begin
                count_r <= count_r;
            end else if (count_r + DDRIO_CNT_ONE >= len) begin
                count_r <= DDRIO_CNT_ZERO;
            end else begin
                count_r <= count_r + DDRIO_CNT_ONE;
            end
        end
    end

    // lane mapping of the finished word
    always_comb begin
        word_nxt = DDRIO_WORD_RST;
        case (gb_mode_in)
            DDRIO_GB_BY7: word_nxt = {1'b0, shift_a_r[5:0], bit_a_in};
            DDRIO_GB_BY8: word_nxt = {shift_a_r[6:0], bit_a_in};
            DDRIO_GB_DUAL_BY4: word_nxt = {shift_a_r[2:0], bit_a_in,
                                           shift_b_r[2:0], bit_b_in};
            default: word_nxt = DDRIO_WORD_RST;
        endcase
    end

    // word register, loaded at the boundary
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_out <= DDRIO_WORD_RST;
            word_valid_out <= 1'b0;
        end else begin
            word_valid_out <= 1'b0;
            if (bit_a_valid_in && !word_align_req_in &&
                (count_r + DDRIO_CNT_ONE >= len)) begin
                word_out <= word_nxt;
                word_valid_out <= 1'b1;
            end
        end
    end

endmodule // ddrio_deser

// ===== dv/ddrio_gearbox_chk.sv
// checker: port-level properties of the pin register block
`timescale 1ns/10ps
module ddrio_gearbox_chk
    import ddrio_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] out_mode_in,
    input wire logic latch_mode_in,
    input wire logic out_data_rise_in,
    input wire logic out_data_fall_in,
    input wire logic tristate_ctrl_in,
    input wire logic write_strobe_shifted_in,
    input wire logic pin_data_out,
    input wire logic pin_oe_out,
    input wire logic [1:0] gb_mode_in,
    input wire logic [7:0] gb_word_out,
    input wire logic gb_word_valid_out
);
    logic [1:0] up_r;
    logic up;
    logic sgl;
    logic gen;
    logic mem;
    // internal reset copy lags the release, so trust outputs from edge three
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    assign up = (up_r == 2'h3);
    assign sgl = up && out_mode_in == DDRIO_OUT_SINGLE;
    assign gen = up && out_mode_in == DDRIO_OUT_GENERIC;
    assign mem = out_mode_in == DDRIO_OUT_MEMORY;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    // --------
    // output, enable and gearbox relations
    // --------
    single_flop_a: assert property (sgl && !latch_mode_in && $past(sgl)
        |-> pin_data_out == $past(out_data_rise_in)) else $error("single out");
    generic_rise_a: assert property (@(negedge clk_in) gen && $past(gen)
        |-> pin_data_out == $past(out_data_rise_in)) else $error("rise stage");
    generic_fall_a: assert property (gen && $past(gen)
        |-> pin_data_out == $past(out_data_fall_in)) else $error("fall stage");
    oe_single_a: assert property (sgl && $past(sgl)
        |-> pin_oe_out == $past(tristate_ctrl_in)) else $error("single oe");
    mem_oe_hold_a: assert property ((mem && !write_strobe_shifted_in)[*5]
        |=> $stable(pin_oe_out)) else $error("oe moved without strobe");
    mem_oe_load_a: assert property (up && mem && tristate_ctrl_in
        && $past(tristate_ctrl_in) && $rose(write_strobe_shifted_in)
        |-> ##[1:5] pin_oe_out) else $error("oe not loaded by strobe");
    word_pulse_a: assert property (gb_word_valid_out
        |=> !gb_word_valid_out) else $error("word valid too long");
    word_hold_a: assert property (up && $changed(gb_word_out)
        |-> gb_word_valid_out) else $error("word changed without valid");
    by7_top_a: assert property (gb_word_valid_out && gb_mode_in == DDRIO_GB_BY7
        |-> !gb_word_out[7]) else $error("top lane set in 1:7");
    reset_clear_a: assert property (disable iff (1'b0) !rstn_in
        |-> gb_word_out == DDRIO_WORD_RST && !gb_word_valid_out && !pin_oe_out)
        else $error("outputs not cleared in reset");
    cover property (gb_word_valid_out && gb_mode_in == DDRIO_GB_DUAL_BY4);
    cover property (mem && $rose(pin_oe_out));
    cover property (gen && $changed(pin_data_out));
endmodule // ddrio_gearbox_chk

bind ddrio_gearbox ddrio_gearbox_chk ddrio_gearbox_chk_i (.*);

// ===== dv/ddrio_far_end.sv
// partner: serial source and memory device on the pin side
`timescale 1ns/10ps
module ddrio_far_end (
    output logic link_clk_out,
    output logic ser_a_out,
    output logic ser_b_out,
    output logic pin_d_out,
    output logic rd_strobe_out
);
    // idle: link clock stands still between frames
    initial begin
        link_clk_out = 1'b0;
        ser_a_out = 1'b0;
        ser_b_out = 1'b0;
        pin_d_out = 1'b0;
        rd_strobe_out = 1'b0;
    end
    // one bit per link edge, msb first; data moves mid-phase for margin
    task automatic send(input logic [8:0] a, input logic [8:0] b, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            ser_a_out = a[i];
            ser_b_out = b[i];
            #80;
            link_clk_out = ~link_clk_out;
            #80;
        end
        // hold over: show the inverse so a stale bit never passes
        ser_a_out = ~a[0];
        ser_b_out = ~b[0];
    endtask
    // one read beat pair on the shifted read strobe
    task automatic rd_pair(input logic r, input logic f);
        pin_d_out = r;
        #120;
        rd_strobe_out = 1'b1;
        #120;
        pin_d_out = f;
        #120;
        rd_strobe_out = 1'b0;
        #120;
        pin_d_out = ~f;
    endtask
endmodule // ddrio_far_end

// ===== dv/ddrio_gearbox_test.sv
// testbench: directed checks of the pin register block
`timescale 1ns/10ps
module ddrio_gearbox_test;
    import ddrio_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in;
    logic [1:0] out_mode_in, gb_mode_in, mem_rd_data_out;
    logic latch_mode_in, out_data_rise_in, out_data_fall_in, tristate_ctrl_in;
    logic write_strobe_shifted_in, read_strobe_shifted_in, pin_data_in;
    logic sync_clock_polarity_in, pin_data_out, pin_oe_out, gb_word_valid_out;
    logic fast_edge_clock_in, ser_data_a_in, ser_data_b_in, word_align_req_in;
    logic [7:0] gb_word_out, exp_w;
    int n_errors = 0;
    int checked = 0;
    always #20 clk_in = ~clk_in;
    ddrio_gearbox ddrio_gearbox_i (.*);
    ddrio_far_end ddrio_far_end_i (
        .link_clk_out(fast_edge_clock_in),
        .ser_a_out(ser_data_a_in),
        .ser_b_out(ser_data_b_in),
        .pin_d_out(pin_data_in),
        .rd_strobe_out(read_strobe_shifted_in)
    );
    task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // sample well after the edge so design updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask
    task automatic do_reset();
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic wait_word(input logic [7:0] e);
        int k;
        k = 0;
        @(negedge clk_in);
        while (gb_word_valid_out !== 1'b1 && k < 300) begin
            @(negedge clk_in);
            k++;
        end
        cmp("word valid", 8'h1, {7'h0, gb_word_valid_out});
        cmp("word", e, gb_word_out);
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hang guard: the sequence needs well under this span
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end
    initial begin
        // a real falling edge at time zero, so the async resets do fire
        rstn_in = 1'b0;
        {out_mode_in, gb_mode_in, latch_mode_in, out_data_rise_in} = '0;
        {out_data_fall_in, tristate_ctrl_in, write_strobe_shifted_in} = '0;
        {sync_clock_polarity_in, word_align_req_in} = '0;
        do_reset();
        // flop shows the old bit in the high phase, latch passes the new one
        for (int i = 1; i < 5; i++) begin
            @(posedge clk_in);
            latch_mode_in <= i[1];
            out_data_rise_in <= i[0];
            tristate_ctrl_in <= i[0];
            #10;
            exp_w = {7'h0, i[1] ? i[0] : ~i[0]};
            cmp("single pin", exp_w, {7'h0, pin_data_out});
            cmp("single oe", {7'h0, ~i[0]}, {7'h0, pin_oe_out});
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_in);
            out_mode_in <= DDRIO_OUT_GENERIC;
            out_data_rise_in <= i[0];
            out_data_fall_in <= ~i[0];
            settle(2);
            cmp("generic high", {7'h0, i[0]}, {7'h0, pin_data_out});
            @(negedge clk_in);
            #10;
            cmp("generic low", {7'h0, ~i[0]}, {7'h0, pin_data_out});
        end
        // memory mode: enable waits for a write strobe rise
        @(posedge clk_in);
        out_mode_in <= DDRIO_OUT_MEMORY;
        out_data_rise_in <= 1'b1;
        out_data_fall_in <= 1'b0;
        tristate_ctrl_in <= 1'b1;
        settle(6);
        cmp("mem oe idle", 8'h0, {7'h0, pin_oe_out});
        @(posedge clk_in);
        write_strobe_shifted_in <= 1'b1;
        settle(6);
        cmp("mem pin high", 8'h1, {7'h0, pin_data_out});
        cmp("mem oe set", 8'h1, {7'h0, pin_oe_out});
        @(posedge clk_in);
        write_strobe_shifted_in <= 1'b0;
        tristate_ctrl_in <= 1'b0;
        settle(6);
        cmp("mem pin low", 8'h0, {7'h0, pin_data_out});
        cmp("mem oe held", 8'h1, {7'h0, pin_oe_out});
        // pairs sent twice so either resync edge has seen both beats
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_in);
            sync_clock_polarity_in <= p[1];
            repeat (2) ddrio_far_end_i.rd_pair(p[0], ~p[0]);
            settle(8);
            exp_w = {6'h0, ~p[0], p[0]};
            cmp("mem read", exp_w, {6'h0, mem_rd_data_out});
        end
        for (int m = 1; m < 3; m++) begin
            do_reset();
            gb_mode_in <= m[1:0];
            exp_w = (m == 1) ? 8'hc3 : 8'h3a;
            fork
                ddrio_far_end_i.send(9'h0c3, 9'h05a, (m == 1) ? 8 : 4);
                wait_word(exp_w);
            join
        end
        // slip: first bit shifted in but not counted
        do_reset();
        gb_mode_in <= DDRIO_GB_BY7;
        word_align_req_in <= 1'b1;
        fork
            ddrio_far_end_i.send(9'h0a5, 9'h000, 8);
            begin
                repeat (6) @(posedge clk_in);
                word_align_req_in <= 1'b0;
            end
            wait_word(8'h25);
        join
        print_verdict();
    end
endmodule // ddrio_gearbox_test
